// file: hw/crb_alu.v
`timescale 1ns/1ps
// byte-wide arithmetic unit, n and z from the byte result, h and c from the wider sums or shift-out bit
module crb_alu (
    input  wire [7:0] opa,      // accumulator low byte
    input  wire [7:0] opb,      // temp operand low byte
    input  wire       cin,      // current carry flag
    input  wire [3:0] op,       // operation code
    output reg  [7:0] res,      // result byte
    output reg  [4:0] flg,      // {h, n, z, v, c}
    output reg  [4:0] upd       // which flags the op changes
);
`include "crb_consts.vh"
    reg [8:0] sum;    // nine-bit sum for carry out
    reg [4:0] lo;     // nibble sum for half carry
    reg       arith;  // add or subtract type
    reg       subt;   // subtract type
    reg       cuse;   // carry participates
    // combinational operation and flag generation
    always @* begin
        arith = (op <= `CRB_OP_SUBC);
        subt  = (op == `CRB_OP_SUB) || (op == `CRB_OP_SUBC);
        cuse  = (op == `CRB_OP_ADDC) || (op == `CRB_OP_SUBC);
        sum   = 9'h000;
        lo    = 5'h00;
        res   = 8'h00;
        flg   = 5'h00;
        upd   = 5'h0E;
        if (arith) begin
            // borrow taken as carry from the direct nine-bit difference
            if (subt) begin
                sum = {1'b0, opa} - {1'b0, opb} - {8'h00, cuse & cin};
                lo  = {1'b0, opa[3:0]} - {1'b0, opb[3:0]}
                    - {4'h0, cuse & cin};
            end else begin
                sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cuse & cin};
                lo  = {1'b0, opa[3:0]} + {1'b0, opb[3:0]}
                    + {4'h0, cuse & cin};
            end
            res    = sum[7:0];
            flg[4] = lo[4];
            flg[0] = sum[8];
            flg[1] = subt ? ((opa[7] ^ opb[7]) & (opa[7] ^ res[7]))
                          : (~(opa[7] ^ opb[7]) & (opa[7] ^ res[7]));
            upd    = 5'h1F;
        end else if (op == `CRB_OP_SHL) begin
            res    = {opa[6:0], 1'b0};
            flg[0] = opa[7];
            upd    = 5'h0F;
        end else if (op == `CRB_OP_SHR) begin
            res    = {1'b0, opa[7:1]};
            flg[0] = opa[0];
            upd    = 5'h0F;
        end else if (op == `CRB_OP_AND) begin
            res = opa & opb;
        end else if (op == `CRB_OP_OR) begin
            res = opa | opb;
        end else begin
            res = opa ^ opb;
        end
        flg[3] = res[7];
        flg[2] = (res == 8'h00);
    end
endmodule

// file: hw/crb_consts.vh
`ifndef CRB_CONSTS_VH
`define CRB_CONSTS_VH
// register word offsets on the bus (byte addresses)
`define CRB_OFS_IP        8'h00
`define CRB_OFS_ACC       8'h04
`define CRB_OFS_TMP       8'h08
`define CRB_OFS_IDX       8'h0C
`define CRB_OFS_MPTR      8'h10
`define CRB_OFS_STK       8'h14
`define CRB_OFS_PSW       8'h18
`define CRB_OFS_ALU_CMD   8'h1C
`define CRB_OFS_BANK_BASE 8'h20
`define CRB_OFS_PROBE     8'h24
`define CRB_OFS_STATUS    8'h28
`define CRB_OFS_GPR_WIN   8'h40
// reset values
`define CRB_RST_WORD      16'h0000
`define CRB_RST_PSW       16'h0030
// condition flag, level mask and interrupt enable bit positions in the status word
`define CRB_BIT_C         0
`define CRB_BIT_V         1
`define CRB_BIT_Z         2
`define CRB_BIT_N         3
`define CRB_BIT_PRIO_LO   4
`define CRB_BIT_PRIO_HI   5
`define CRB_BIT_I         6
`define CRB_BIT_H         7
// bank pointer field inside the upper byte
`define CRB_BANK_LSB      11
`define CRB_BANK_MSB      15
// address space layout
`define CRB_IO_BASE       16'h0000
`define CRB_DATA_BASE     16'h0080
`define CRB_DATA_END      16'h047F
`define CRB_PROG_BASE     16'h8000
`define CRB_VEC_BASE      16'hFFC0
// region codes
`define CRB_REG_IO        2'h0
`define CRB_REG_DATA      2'h1
`define CRB_REG_PROG      2'h2
`define CRB_REG_NONE      2'h3
// alu operation codes
`define CRB_OP_ADD        4'h0
`define CRB_OP_ADDC       4'h1
`define CRB_OP_SUB        4'h2
`define CRB_OP_SUBC       4'h3
`define CRB_OP_SHL        4'h4
`define CRB_OP_SHR        4'h5
`define CRB_OP_AND        4'h6
`define CRB_OP_OR         4'h7
`define CRB_OP_XOR        4'h8
// bus responses
`define CRB_RESP_OKAY     2'h0
`define CRB_RESP_SLVERR   2'h2
`endif

// file: hw/crb_core.v
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
//
// Overview of operation
// - one linear 64-Kbyte space for all areas
// - io area lowest, data area directly above
// - program area at top, vectors highest
// - 16-bit instruction pointer holds fetch address
// - 16-bit accumulator, byte ops use low byte
// - 16-bit temp operand partners accumulator, low byte
// - index, memory pointer and stack pointer registers
// - status word: bank pointer high, flags low
// - half carry from bit 3 to 4
// - interrupt enable gates interrupts, reset clears
// - level mask admits only higher priority requests
// - negative follows result most significant bit
// - zero set when result is zero
// - overflow on two's complement range overflow
// - carry out of bit 7, shift-out bit
// - bank pointer selects active register bank
// - eight 8-bit registers per bank, sixteen banks
// - only lower half of bank space usable
module crb_core #(
    parameter ADDR_W = 8,    // bus address width
    parameter BANKS  = 16    // usable register banks
) (
    input  wire              aclk,           // core clock
    input  wire              aresetn,        // sync reset, active low
    input  wire [ADDR_W-1:0] s_axi_awaddr,   // write address
    input  wire              s_axi_awvalid,  // write address valid
    output wire              s_axi_awready,  // write address ready
    input  wire [31:0]       s_axi_wdata,    // write data
    input  wire [3:0]        s_axi_wstrb,    // write byte enables
    input  wire              s_axi_wvalid,   // write data valid
    output wire              s_axi_wready,   // write data ready
    output wire [1:0]        s_axi_bresp,    // write response
    output wire              s_axi_bvalid,   // write response valid
    input  wire              s_axi_bready,   // write response ready
    input  wire [ADDR_W-1:0] s_axi_araddr,   // read address
    input  wire              s_axi_arvalid,  // read address valid
    output wire              s_axi_arready,  // read address ready
    output wire [31:0]       s_axi_rdata,    // read data
    output wire [1:0]        s_axi_rresp,    // read response
    output wire              s_axi_rvalid,   // read data valid
    input  wire              s_axi_rready,   // read data ready
    input  wire              irq_req,        // interrupt request
    input  wire [1:0]        irq_level,      // request level code
    output wire              irq_admit,      // request admitted
    output wire [15:0]       instruction_pointer, // fetch address
    output wire [15:0]       bank_base_addr  // active bank address
);
`include "crb_consts.vh"
    localparam GPR_N = BANKS * 8;            // general register count

    // register select codes
    localparam SEL_IP   = 4'h0;
    localparam SEL_ACC  = 4'h1;
    localparam SEL_TMP  = 4'h2;
    localparam SEL_IDX  = 4'h3;
    localparam SEL_MPTR = 4'h4;
    localparam SEL_STK  = 4'h5;
    localparam SEL_PSW  = 4'h6;
    localparam SEL_ALU  = 4'h7;
    localparam SEL_BASE = 4'h8;
    localparam SEL_PRB  = 4'h9;
    localparam SEL_STAT = 4'hA;
    localparam SEL_GPR  = 4'hB;
    localparam SEL_NONE = 4'hF;

    // decodes a byte address into a register select code
    function [3:0] reg_sel;
        input [ADDR_W-1:0] adr;
        begin
            case ({adr[ADDR_W-1:2], 2'b00})
                `CRB_OFS_IP:        reg_sel = SEL_IP;
                `CRB_OFS_ACC:       reg_sel = SEL_ACC;
                `CRB_OFS_TMP:       reg_sel = SEL_TMP;
                `CRB_OFS_IDX:       reg_sel = SEL_IDX;
                `CRB_OFS_MPTR:      reg_sel = SEL_MPTR;
                `CRB_OFS_STK:       reg_sel = SEL_STK;
                `CRB_OFS_PSW:       reg_sel = SEL_PSW;
                `CRB_OFS_ALU_CMD:   reg_sel = SEL_ALU;
                `CRB_OFS_BANK_BASE: reg_sel = SEL_BASE;
                `CRB_OFS_PROBE:     reg_sel = SEL_PRB;
                `CRB_OFS_STATUS:    reg_sel = SEL_STAT;
                default: begin
                    if ((adr[ADDR_W-1:5] == `CRB_OFS_GPR_WIN >> 5)
                        && (adr[ADDR_W-1:5] != 0))
                        reg_sel = SEL_GPR;
                    else
                        reg_sel = SEL_NONE;
                end
            endcase
        end
    endfunction

    // merges byte lanes of a write into a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] d;
        input [3:0]  s;
        begin
            merge16[7:0]  = s[0] ? d[7:0]  : old[7:0];
            merge16[15:8] = s[1] ? d[15:8] : old[15:8];
        end
    endfunction

    // architectural registers
    reg [15:0] ip_reg;         // instruction pointer
    reg [15:0] acc_reg;        // accumulator
    reg [15:0] tmp_reg;        // temp operand
    reg [15:0] idx_reg;        // offset base register
    reg [15:0] mptr_reg;       // memory pointer
    reg [15:0] stk_reg;        // stack top pointer
    reg [15:0] psw_reg;        // processor state word
    reg [3:0]  alu_op_reg;     // last operation issued
    reg [15:0] probe_reg;      // address under inspection
    reg        irq_admit_reg;  // admitted request
    reg [15:0] base_out_reg;   // active bank address, port copy
    reg [7:0]  gpr_mem [0:GPR_N-1]; // banked general registers
    // bus slave state
    reg              aw_got_reg;   // write address held
    reg              w_got_reg;    // write data held
    reg [ADDR_W-1:0] awaddr_reg;   // held write address
    reg [31:0]       wdata_reg;    // held write data
    reg [3:0]        wstrb_reg;    // held byte enables
    reg              bvalid_reg;   // response pending
    reg [1:0]        bresp_reg;    // response code
    reg              rvalid_reg;   // read data pending
    reg [31:0]       rdata_reg;    // read data
    reg [1:0]        rresp_reg;    // read response code

    // bank pointer and derived values
    wire [7:0]  bank_ptr  = psw_reg[15:8];
    wire [7:0]  cond_flg  = psw_reg[7:0];
    wire [4:0]  bank_idx  = psw_reg[`CRB_BANK_MSB:`CRB_BANK_LSB];
    wire [1:0]  prio_mask = psw_reg[`CRB_BIT_PRIO_HI:`CRB_BIT_PRIO_LO];
    wire [1:0]  region;        // region of probe address
    wire        vec_area;      // probe in vector area
    wire [15:0] bank_base;     // active bank byte address
    wire        bank_ok;       // active bank usable
    wire [7:0]  alu_res;       // alu result byte
    wire [4:0]  alu_flg;       // alu flag values
    wire [4:0]  alu_upd;       // alu flag update mask

    // address map and bank location
    crb_mem_map #(
        .BANKS     (BANKS)
    ) u_map (
        .addr      (probe_reg),
        .bank_idx  (bank_idx),
        .region    (region),
        .vec_area  (vec_area),
        .bank_base (bank_base),
        .bank_ok   (bank_ok)
    );

    // byte arithmetic on the low bytes of accumulator and temp
    crb_alu u_alu (
        .opa (acc_reg[7:0]),
        .opb (tmp_reg[7:0]),
        .cin (psw_reg[`CRB_BIT_C]),
        .op  (wdata_reg[3:0]),
        .res (alu_res),
        .flg (alu_flg),
        .upd (alu_upd)
    );

    // handshakes: one write and one read under way at a time
    wire do_write = aw_got_reg & w_got_reg & ~bvalid_reg;
    wire [3:0] wsel = reg_sel(awaddr_reg);
    wire [3:0] rsel = reg_sel(s_axi_araddr);
    wire [2:0] wgpr = awaddr_reg[4:2];       // register in bank, write
    wire [2:0] rgpr = s_axi_araddr[4:2];     // register in bank, read
    wire [6:0] wgpr_a = {bank_idx[3:0], wgpr};
    wire [6:0] rgpr_a = {bank_idx[3:0], rgpr};
    wire       ar_hs = s_axi_arvalid & ~rvalid_reg;

    assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_got_reg & ~bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign irq_admit     = irq_admit_reg;
    assign instruction_pointer = ip_reg;
    assign bank_base_addr      = base_out_reg;

    // next status word after a bus write or an alu operation
    reg [15:0] psw_next;
    always @* begin
        psw_next = psw_reg;
        if (do_write && wsel == SEL_PSW) begin
            psw_next = merge16(psw_reg, wdata_reg, wstrb_reg);
        end else if (do_write && wsel == SEL_ALU && wstrb_reg[0]) begin
            // only flags named by the operation change
            if (alu_upd[4])
                psw_next[`CRB_BIT_H] = alu_flg[4];
            if (alu_upd[3])
                psw_next[`CRB_BIT_N] = alu_flg[3];
            if (alu_upd[2])
                psw_next[`CRB_BIT_Z] = alu_flg[2];
            if (alu_upd[1])
                psw_next[`CRB_BIT_V] = alu_flg[1];
            if (alu_upd[0])
                psw_next[`CRB_BIT_C] = alu_flg[0];
        end
    end

    // write channel capture and response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awaddr_reg <= {ADDR_W{1'b0}};
            wdata_reg  <= 32'h00000000;
            wstrb_reg  <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg  <= `CRB_RESP_OKAY;
        end else begin
            // address and data taken in either order
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
                bvalid_reg <= 1'b1;
                // unmapped, read-only or unusable bank answer error
                if (wsel == SEL_NONE || wsel == SEL_BASE ||
                    wsel == SEL_STAT || (wsel == SEL_GPR && !bank_ok))
                    bresp_reg <= `CRB_RESP_SLVERR;
                else
                    bresp_reg <= `CRB_RESP_OKAY;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // architectural register updates
    always @(posedge aclk) begin
        if (!aresetn) begin
            ip_reg     <= `CRB_RST_WORD;
            acc_reg    <= `CRB_RST_WORD;
            tmp_reg    <= `CRB_RST_WORD;
            idx_reg    <= `CRB_RST_WORD;
            mptr_reg   <= `CRB_RST_WORD;
            stk_reg    <= `CRB_RST_WORD;
            psw_reg    <= `CRB_RST_PSW;
            alu_op_reg <= 4'h0;
            probe_reg  <= `CRB_RST_WORD;
        end else begin
            psw_reg <= psw_next;
            if (do_write) begin
                case (wsel)
                    SEL_IP:   ip_reg   <= merge16(ip_reg, wdata_reg,
                                                  wstrb_reg);
                    SEL_ACC:  acc_reg  <= merge16(acc_reg, wdata_reg,
                                                  wstrb_reg);
                    SEL_TMP:  tmp_reg  <= merge16(tmp_reg, wdata_reg,
                                                  wstrb_reg);
                    SEL_IDX:  idx_reg  <= merge16(idx_reg, wdata_reg,
                                                  wstrb_reg);
                    SEL_MPTR: mptr_reg <= merge16(mptr_reg, wdata_reg,
                                                  wstrb_reg);
                    SEL_STK:  stk_reg  <= merge16(stk_reg, wdata_reg,
                                                   wstrb_reg);
                    SEL_PRB:  probe_reg <= merge16(probe_reg, wdata_reg,
                                                   wstrb_reg);
                    SEL_ALU: begin
                        if (wstrb_reg[0]) begin
                            alu_op_reg   <= wdata_reg[3:0];
                            acc_reg[7:0] <= alu_res;
                        end
                    end
                    default: begin
                        // nothing stored for other selects
                    end
                endcase
            end
        end
    end

    // banked general registers in data memory
    always @(posedge aclk) begin
        if (do_write && wsel == SEL_GPR && bank_ok && wstrb_reg[0])
            gpr_mem[wgpr_a] <= wdata_reg[7:0];
    end

    // read data selection
    reg [31:0] rdata_next;
    reg [1:0]  rresp_next;
    always @* begin
        rdata_next = 32'h00000000;
        rresp_next = `CRB_RESP_OKAY;
        case (rsel)
            SEL_IP:   rdata_next[15:0] = ip_reg;
            SEL_ACC:  rdata_next[15:0] = acc_reg;
            SEL_TMP:  rdata_next[15:0] = tmp_reg;
            SEL_IDX:  rdata_next[15:0] = idx_reg;
            SEL_MPTR: rdata_next[15:0] = mptr_reg;
            SEL_STK:  rdata_next[15:0] = stk_reg;
            SEL_PSW:  rdata_next[15:0] = {bank_ptr, cond_flg};
            SEL_ALU:  rdata_next[3:0]  = alu_op_reg;
            SEL_BASE: rdata_next[15:0] = bank_base;
            SEL_PRB:  rdata_next[15:0] = probe_reg;
            SEL_STAT: begin
                // live view of map, bank and interrupt state
                rdata_next[1:0] = region;
                rdata_next[2]   = vec_area;
                rdata_next[3]   = bank_ok;
                rdata_next[4]   = irq_admit_reg;
                rdata_next[9:5] = bank_idx;
            end
            SEL_GPR: begin
                if (bank_ok)
                    rdata_next[7:0] = gpr_mem[rgpr_a];
                else
                    rresp_next = `CRB_RESP_SLVERR;
            end
            default: rresp_next = `CRB_RESP_SLVERR;
        endcase
    end

    // read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= `CRB_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // interrupt admission: enable set and level code below mask
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_admit_reg <= 1'b0;
        end else begin
            irq_admit_reg <= irq_req && psw_reg[`CRB_BIT_I]
                             && (irq_level < prio_mask);
        end
    end

    // registered copy of the active bank address for the port
    always @(posedge aclk) begin
        if (!aresetn)
            base_out_reg <= `CRB_DATA_BASE;
        else
            base_out_reg <= bank_base;
    end
endmodule

// file: hw/crb_mem_map.v
`timescale 1ns/1ps
// address region decode and active bank location
module crb_mem_map #(
    parameter BANKS = 16   // usable banks, lower half of the pointer space
) (
    input  wire [15:0] addr,       // probed address
    input  wire [4:0]  bank_idx,   // bank pointer field
    output reg  [1:0]  region,     // region code
    output wire        vec_area,   // address in vector table area
    output wire [15:0] bank_base,  // byte address of active bank
    output wire        bank_ok     // bank lies in usable half
);
`include "crb_consts.vh"
    // io lowest, data directly above, program at the top
    always @* begin
        if (addr < `CRB_DATA_BASE)
            region = `CRB_REG_IO;
        else if (addr <= `CRB_DATA_END)
            region = `CRB_REG_DATA;
        else if (addr >= `CRB_PROG_BASE)
            region = `CRB_REG_PROG;
        else
            region = `CRB_REG_NONE;
    end
    assign vec_area  = (addr >= `CRB_VEC_BASE);
    assign bank_base = `CRB_DATA_BASE + {8'h00, bank_idx, 3'b000};
    assign bank_ok   = ({27'h0, bank_idx} < BANKS);
endmodule

// file: verification/crb_core_monitor.sv
`timescale 1ns/1ps
// bus handshake timing and interrupt gate checks
module crb_core_monitor #(
    parameter BANKS = 16             // usable banks
) (
    input wire        aclk,          // clock
    input wire        aresetn,       // sync reset
    input wire        s_axi_awvalid, // aw valid
    input wire        s_axi_awready, // aw ready
    input wire        s_axi_wvalid,  // w valid
    input wire        s_axi_wready,  // w ready
    input wire        s_axi_bvalid,  // b valid
    input wire        s_axi_bready,  // b ready
    input wire        s_axi_arvalid, // ar valid
    input wire        s_axi_arready, // ar ready
    input wire [31:0] s_axi_rdata,   // read data
    input wire        s_axi_rvalid,  // r valid
    input wire        s_axi_rready,  // r ready
    input wire        irq_req,       // request
    input wire [1:0]  irq_level,     // request level
    input wire        irq_admit      // admitted
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write halves taken on one edge
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // read address taken
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (
        s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    a_busy_refuse: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    a_admit_cause: assert property (
        irq_admit |-> $past(irq_req) && $past(irq_level) != 2'h3)
        else $error("admit without request");
    a_lowest_blocked: assert property (
        irq_req && irq_level == 2'h3 |=> !irq_admit)
        else $error("lowest admitted");
endmodule
bind crb_core crb_core_monitor #(.BANKS(BANKS)) u_monitor (.*);

// file: verification/tb.sv
`timescale 1ns/1ps
`include "crb_consts.vh"
module tb;
    logic        aclk = 0, aresetn = 0, irq_req = 0;   // clock, reset, request
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;  // read handshake
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;   // byte addresses
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;     // data, last read
    logic [3:0]  s_axi_wstrb = 4'hF;                   // all lanes
    logic [1:0]  irq_level = 0, s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, irq_admit;              // dut outputs
    logic [15:0] instruction_pointer, bank_base_addr;  // dut outputs
    logic [35:0] row;                                  // {op,a,b,res,flags}
    logic [35:0] alu_tab [10] = '{36'h0_7F_01_80_BA, 36'h0_FF_01_00_B5,
        36'h1_01_01_03_30, 36'h2_00_01_FF_B9, 36'h3_05_02_02_30,
        36'h4_81_00_02_31, 36'h5_01_00_00_35, 36'h6_F0_0F_00_35,
        36'h7_80_01_81_39, 36'h8_5A_5A_00_35};
    logic [10:0] irq_tab [7] = '{11'h301, 11'h303, 11'h304, 11'h306,
        11'h100, 11'h385, 11'h200};                    // {psw,level,admit}
    logic [19:0] map_tab [8] = '{20'h00000, 20'h007F0, 20'h00801,
        20'h047F1, 20'h04803, 20'h80002, 20'hFFBF2, 20'hFFC06};
    int          num_errors = 0, num_checks = 0, i;    // counters
    always #25 aclk = ~aclk;
    crb_core dut (.*);
    // compare one value
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // verdict and end of run
    task conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one bus access, response and read data compared
    task automatic bus(input bit w, input [7:0] adr, input [31:0] d,
                       input [1:0] er, input [31:0] ed, input string nm);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= adr;
        s_axi_araddr <= adr;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) begin
                chk("resp", {30'h0, er}, {30'h0, w ? s_axi_bresp : s_axi_rresp});
                rv = s_axi_rdata;
                if (nm != "") chk(nm, ed, rv);
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                return;
            end
            s_axi_bready <= s_axi_bvalid;
            s_axi_rready <= s_axi_rvalid;
        end
        num_errors++;
        conclude();
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        bus(0, `CRB_OFS_PSW, 0, 0, 32'h30, "psw");
        bus(0, `CRB_OFS_BANK_BASE, 0, 0, 32'h80, "base");
        for (i = 0; i < 6; i++) begin // word registers keep 16 bits
            bus(1, 8'(4 * i), 32'hFFFF_C3E0 + i, 0, 0, "");
            bus(0, 8'(4 * i), 0, 0, 32'hC3E0 + i, "word");
        end
        chk("ip", 32'hC3E0, {16'h0, instruction_pointer});
        s_axi_wstrb <= 4'h2; // high lane only
        bus(1, `CRB_OFS_ACC, 32'h0000_5A11, 0, 0, "");
        s_axi_wstrb <= 4'hF;
        bus(0, `CRB_OFS_ACC, 0, 0, 32'h5AE1, "lanes");
        $display("test registers done");
        for (i = 0; i < 10; i++) begin // every alu code
            row = alu_tab[i];
            bus(1, `CRB_OFS_PSW, 32'h31, 0, 0, "");
            bus(1, `CRB_OFS_ACC, {16'h0, 8'h12, row[31:24]}, 0, 0, "");
            bus(1, `CRB_OFS_TMP, {24'h0, row[23:16]}, 0, 0, "");
            bus(1, `CRB_OFS_ALU_CMD, {28'h0, row[35:32]}, 0, 0, "");
            bus(0, `CRB_OFS_ACC, 0, 0, {16'h0, 8'h12, row[15:8]},
                "acc");
            bus(0, `CRB_OFS_PSW, 0, 0, {24'h0, row[7:0]},
                "flags");
        end
        $display("test alu done");
        for (i = 0; i < 7; i++) begin // enable and mask gate requests
            bus(1, `CRB_OFS_PSW, {24'h0, irq_tab[i][10:3]}, 0, 0, "");
            irq_level <= irq_tab[i][2:1];
            irq_req <= 1'b1;
            repeat (2) @(posedge aclk);
            chk("admit", {31'h0, irq_tab[i][0]}, {31'h0, irq_admit});
            irq_req <= 1'b0;
        end
        $display("test interrupt done");
        bus(1, `CRB_OFS_PSW, 32'h7800, 0, 0, "");
        bus(0, `CRB_OFS_BANK_BASE, 0, 0, 32'hF8, "base");
        chk("base_port", 32'hF8, {16'h0, bank_base_addr});
        bus(1, `CRB_OFS_GPR_WIN + 8'h1C, 32'hA7, 0, 0, "");
        bus(0, `CRB_OFS_GPR_WIN + 8'h1C, 0, 0, 32'hA7, "gpr");
        bus(1, `CRB_OFS_PSW, 32'h8000, 0, 0, "");
        bus(1, `CRB_OFS_GPR_WIN, 32'h55, 2, 0, "");
        bus(1, `CRB_OFS_BANK_BASE, 32'h1, 2, 0, "");
        bus(0, 8'h30, 0, 2, 0, "unmapped");
        $display("test banks done");
        for (i = 0; i < 8; i++) begin // region of probed addresses
            bus(1, `CRB_OFS_PROBE, {16'h0, map_tab[i][19:4]}, 0, 0, "");
            bus(0, `CRB_OFS_STATUS, 0, 0, 0, "");
            chk("region", {29'h0, map_tab[i][2:0]}, {29'h0, rv[2:0]});
        end
        $display("test map done");
        conclude();
    end
endmodule
